// >>> bench/ptg_drive_model.sv
// Stepper drive model decoding count and direction pulses
`timescale 1ns/10ps
`default_nettype none
module ptg_drive_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic count_in,
    input wire logic dir_in,
    output logic [15:0] fwd_cnt,
    output logic [15:0] rev_cnt,
    output logic [15:0] a_rise,
    output logic [15:0] b_rise,
    output logic [31:0] setup_cyc
);
    int cyc;
    int rise_t;
    int dir_t;
    int high_q[$];
    logic count_q;
    logic dir_q;
    logic dir_fresh;
    // Edge decoding with setup and high time capture
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {fwd_cnt, rev_cnt, a_rise, b_rise} <= 64'h0;
            {cyc, rise_t, dir_t, setup_cyc} <= 128'h0;
            {count_q, dir_q, dir_fresh} <= 3'h0;
        end else begin
            cyc <= cyc + 1;
            count_q <= count_in;
            dir_q <= dir_in;
            if (dir_in != dir_q) begin
                dir_t <= cyc;
                dir_fresh <= 1'b1;
                b_rise <= b_rise + 16'(dir_in);
            end
            if (count_in && !count_q) begin
                a_rise <= a_rise + 16'h1;
                if (dir_in) fwd_cnt <= fwd_cnt + 16'h1;
                else rev_cnt <= rev_cnt + 16'h1;
                rise_t <= cyc;
                dir_fresh <= 1'b0;
                if (dir_fresh) setup_cyc <= 32'(cyc - dir_t);
            end
            if (!count_in && count_q) high_q.push_back(cyc - rise_t);
        end
    end
endmodule : ptg_drive_model
`default_nettype wire

// >>> bench/ptg_step_chk.sv
// Bus and output timing checker for the step generator
`include "ptg_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module ptg_step_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic step_output_primary,
    input wire logic step_output_secondary
);
    logic rst_st_reg;
    logic [7:0] gap_reg;
    logic wr_state;
    logic mapped;
    assign wr_state = psel && penable && pready && pwrite && paddr == 8'h00;
    assign mapped = paddr <= 8'h14 && paddr[1:0] == 2'h0;
    // Shadow of the reset state word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_st_reg <= 1'b1;
        end else if (wr_state) begin
            rst_st_reg <= pwdata != `PTG_STATE_IDLE
                && pwdata != `PTG_STATE_ACTIVE;
        end
    end
    // Cycles since the last pin change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_reg <= 8'hFF;
        end else if ($changed(step_output_primary) ||
                     $changed(step_output_secondary)) begin
            gap_reg <= 8'h00;
        end else if (gap_reg != 8'hFF) begin
            gap_reg <= gap_reg + 8'h01;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_next;
        psel && !penable |=> pready;
    endproperty
    a_ready_next: assert property (p_ready_next) else $error("no ready");
    property p_ready_only;
        pready |-> psel && penable && $past(psel && !penable);
    endproperty
    a_ready_only: assert property (p_ready_only) else $error("stray ready");
    property p_err_unmapped;
        psel && !penable && !mapped |=> pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("no slverr");
    property p_err_mapped;
        psel && !penable && mapped |=> !pslverr;
    endproperty
    a_err_mapped: assert property (p_err_mapped) else $error("bad slverr");
    property p_read_zero;
        pready && pslverr && !pwrite |-> prdata == 32'h00000000;
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("unmapped data");
    property p_reset_low;
        rst_st_reg && $past(rst_st_reg, 2) |->
            !step_output_primary && !step_output_secondary;
    endproperty
    a_reset_low: assert property (p_reset_low) else $error("reset pins");
    property p_write_reset;
        wr_state && pwdata == 32'h00000000 |->
            ##[1:2] (!step_output_primary && !step_output_secondary);
    endproperty
    a_write_reset: assert property (p_write_reset) else $error("no low");
    property p_gap;
        $changed(step_output_primary) || $changed(step_output_secondary) |->
            gap_reg >= 8'h64;
    endproperty
    a_gap: assert property (p_gap) else $error("event off tick");
    cover property ($rose(step_output_primary));
    cover property (pready && pslverr);
    cover property (wr_state && pwdata == `PTG_STATE_IDLE);
endmodule : ptg_step_chk
bind ptg_step_generator ptg_step_chk ptg_step_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr),
    .step_output_primary(step_output_primary),
    .step_output_secondary(step_output_secondary));
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the step generator
`include "ptg_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int tick_cyc = `PTG_LOOP_CYC;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic out_a, out_b;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat, setup_cyc;
    logic [15:0] fwd_cnt, rev_cnt, a_rise, b_rise, na, nb;
    logic [1:0] ph;
    int bad_count, total_checks, cyc;
    int acc_exp[5] = '{18, 10, 8, 8, 15};
    always #5 pclk = ~pclk;
    ptg_step_generator ptg_step_generator_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .step_output_primary(out_a),
        .step_output_secondary(out_b));
    ptg_drive_model ptg_drive_model_inst (.pclk(pclk), .presetn(presetn),
        .count_in(out_a), .dir_in(out_b), .fwd_cnt(fwd_cnt),
        .rev_cnt(rev_cnt), .a_rise(a_rise), .b_rise(b_rise),
        .setup_cyc(setup_cyc));
    task check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task print_verdict;
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    // One APB transfer, held until pready
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rdat, exp);
    endtask : rd_chk
    // Submit a command and wait for the return to idle
    task run(input logic [31:0] lo, input logic [31:0] hi);
        xfer(1'b1, `PTG_OFF_CMD_LO, lo);
        xfer(1'b1, `PTG_OFF_CMD_HI, hi);
        rdat = 32'h1;
        while (rdat !== 32'h0) xfer(1'b0, `PTG_OFF_CMD_HI, 32'h0);
        rd_chk(`PTG_OFF_STATE, `PTG_STATE_ACTIVE);
        while (rdat !== `PTG_STATE_IDLE) xfer(1'b0, `PTG_OFF_STATE, 32'h0);
    endtask : run
    // Cycle ceiling
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            $display("Error at %0t: timeout", $time);
            print_verdict;
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`PTG_OFF_STATE, `PTG_STATE_RESET);
        rd_chk(`PTG_OFF_SETUP, 32'(`PTG_SETUP_RST));
        rd_chk(`PTG_OFF_MODE, 32'h0);
        rd_chk(`PTG_OFF_STATUS, 32'h0);
        xfer(1'b0, 8'h20, 32'h0);
        check(32'(rerr), 32'h1);
        check(rdat, 32'h0);
        // A command written in reset is not run
        xfer(1'b1, `PTG_OFF_CMD_LO, 32'd8);
        xfer(1'b1, `PTG_OFF_CMD_HI, 32'h11000001);
        repeat (2000) @(posedge pclk);
        rd_chk(`PTG_OFF_STATE, `PTG_STATE_RESET);
        check(32'({out_a, out_b}), 32'h0);
        check(32'(a_rise), 32'h0);
        xfer(1'b1, `PTG_OFF_CMD_HI, 32'h0);
        xfer(1'b1, `PTG_OFF_STATE, `PTG_STATE_IDLE);
        rd_chk(`PTG_OFF_STATE, `PTG_STATE_IDLE);
        run(32'd8, 32'h11000002);
        check(32'(fwd_cnt), 32'd2);
        check(32'({out_a, out_b}), 32'h1);
        check(32'(ptg_drive_model_inst.high_q[$]), 2 * tick_cyc);
        run(32'd8, 32'h10000001);
        check(32'(a_rise), 32'd2);
        check(32'(out_b), 32'h1);
        run(32'd8, 32'h1F000001);
        check(32'(rev_cnt), 32'd1);
        check(32'(out_b), 32'h0);
        check(setup_cyc, tick_cyc);
        xfer(1'b1, `PTG_OFF_SETUP, 32'd3);
        run(32'd14, 32'h11000001);
        check(32'(ptg_drive_model_inst.high_q[$]), 3 * tick_cyc);
        xfer(1'b1, `PTG_OFF_SETUP, 32'd1);
        ptg_drive_model_inst.high_q.delete();
        run(32'd40, 32'h11800003);
        run(32'd20, 32'h11C00002);
        check(32'(ptg_drive_model_inst.high_q.size()), 32'd5);
        for (int i = 0; i < 5; i++) begin
            check(32'(ptg_drive_model_inst.high_q[i]),
                acc_exp[i] * tick_cyc);
        end
        // Clockwise and counter-clockwise pulses
        xfer(1'b1, `PTG_OFF_MODE, 32'h1);
        {na, nb} = {a_rise, b_rise};
        // Forward first: secondary is left high by the last count/dir run
        run(32'd8, 32'h11000001);
        run(32'd8, 32'h1F000001);
        check(32'({a_rise - na, b_rise - nb}), 32'h00010001);
        check(32'({out_a, out_b}), 32'h0);
        // Quadrature phase forward then back
        xfer(1'b1, `PTG_OFF_MODE, 32'h2);
        for (int i = 0; i < 2; i++) begin
            xfer(1'b0, `PTG_OFF_STATUS, 32'h0);
            ph = rdat[3:2] + ((i == 0) ? 2'h1 : 2'h3);
            run(32'd8, (i == 0) ? 32'h11000001 : 32'h1F000001);
            xfer(1'b0, `PTG_OFF_STATUS, 32'h0);
            check(32'(rdat[3:2]), 32'(ph));
            check(32'({out_a, out_b}), 32'({ph[1], ph[1] ^ ph[0]}));
        end
        xfer(1'b1, `PTG_OFF_STATE, `PTG_STATE_RESET);
        repeat (3) @(posedge pclk);
        check(32'({out_a, out_b}), 32'h0);
        print_verdict;
    end
endmodule : testbench
`default_nettype wire

// >>> src/ptg_defs.svh
// Register map, field layout, state codes and timing for the step generator
`ifndef PTG_DEFS_SVH
`define PTG_DEFS_SVH

// Register byte offsets
`define PTG_OFF_STATE 8'h00
`define PTG_OFF_CMD_LO 8'h04
`define PTG_OFF_CMD_HI 8'h08
`define PTG_OFF_STATUS 8'h0C
`define PTG_OFF_MODE 8'h10
`define PTG_OFF_SETUP 8'h14

// State word codes
`define PTG_STATE_RESET 32'h00000000
`define PTG_STATE_IDLE 32'h40000000
`define PTG_STATE_ACTIVE 32'h80000000

// Command word fields
`define PTG_CMD_NEW_BIT 28
`define PTG_DIR_MSB 27
`define PTG_DIR_LSB 24
`define PTG_ACC_MSB 23
`define PTG_ACC_LSB 22
`define PTG_CNT_MSB 19
`define PTG_WID_MSB 27
`define PTG_DIR_FWD 4'h1
`define PTG_DIR_REV 4'hF
`define PTG_ACC_DEC 2'h3
`define PTG_ACC_ACC 2'h2

// Width series constants
`define PTG_DEN_ACC_SEED 32'h00000005
`define PTG_DEN_DEC_OFS 32'h00000005
`define PTG_DEN_STEP 32'h00000004
`define PTG_MIN_WIDTH 28'h0000004

// Reset values
`define PTG_SETUP_RST 8'h01
`define PTG_MODE_RST 2'h0

// Loop resolution period
`define PTG_CLK_NS 10
`define PTG_LOOP_NS 1160
`define PTG_LOOP_CYC (`PTG_LOOP_NS / `PTG_CLK_NS)

`endif

// >>> src/ptg_divider.sv
// Iterative restoring divider for the pulse width update
`timescale 1ns/10ps
`default_nettype none
module ptg_divider (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [31:0] numer,
    input wire logic [31:0] denom,
    output logic done,
    output logic [31:0] quot
);
    logic [32:0] rem_reg;
    logic [31:0] q_reg;
    logic [31:0] d_reg;
    logic [5:0] cnt_reg;
    logic busy_reg;
    logic [32:0] trial;

    // Shift in next bit, try a subtraction
    assign trial = {rem_reg[31:0], q_reg[31]} - {1'b0, d_reg};

    // One quotient bit per cycle; remainder restored on a negative trial
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rem_reg <= 33'h000000000;
            q_reg <= 32'h00000000;
            d_reg <= 32'h00000000;
            cnt_reg <= 6'h00;
            busy_reg <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                rem_reg <= 33'h000000000;
                q_reg <= numer;
                d_reg <= denom;
                cnt_reg <= 6'h20;
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                if (trial[32]) begin
                    rem_reg <= {rem_reg[31:0], q_reg[31]};
                    q_reg <= {q_reg[30:0], 1'b0};
                end else begin
                    rem_reg <= trial;
                    q_reg <= {q_reg[30:0], 1'b1};
                end
                cnt_reg <= cnt_reg - 6'h01;
                if (cnt_reg == 6'h01) begin
                    busy_reg <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

    assign quot = q_reg;
endmodule : ptg_divider
`default_nettype wire

// >>> src/ptg_pkg.sv
// Types shared by the step generator files
package ptg_pkg;
    typedef enum logic [1:0] {
        PTG_MODE_CNTDIR,
        PTG_MODE_CWCCW,
        PTG_MODE_QUAD,
        PTG_MODE_SPARE
    } ptg_mode_e;
    typedef enum logic [1:0] {
        ENG_IDLE,
        ENG_START,
        ENG_RUN,
        ENG_DIV
    } ptg_eng_e;
endpackage : ptg_pkg

// >>> src/ptg_step_generator.sv
// Pulse train step generator with APB register access
//
// Chosen here: the APB slave port and the address map.
`include "ptg_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module ptg_step_generator
    import ptg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic step_output_primary,
    output logic step_output_secondary
);
    localparam int unsigned LOOP_CYC = `PTG_LOOP_CYC;

    logic [31:0] state_word_reg;
    logic [31:0] command_word_low_reg;
    logic [31:0] command_word_high_reg;
    logic [1:0] mode_reg;
    logic [7:0] setup_reg;
    logic [7:0] pre_reg;
    logic [24:0] tb_reg;
    logic tick_reg;
    ptg_eng_e eng_reg;
    logic [27:0] width_reg;
    logic [19:0] count_reg;
    logic [3:0] dir_reg;
    logic [1:0] acc_reg;
    logic [31:0] denom_reg;
    logic [1:0] phase_reg;
    logic [24:0] ev_t_reg [4];
    logic [3:0] pend_reg;
    logic [3:0] hit;
    logic acc_en;
    logic wr_en;
    logic mapped;
    logic [31:0] rd_data;
    logic is_reset;
    logic is_idle;
    logic is_active;
    logic cmd_new;
    logic end_last;
    logic accept;
    logic go_idle;
    logic div_start;
    logic div_done;
    logic [31:0] div_quot;
    logic [27:0] delta;
    logic [27:0] half_width_shift;
    logic [24:0] end_event_time;
    logic [24:0] mid_event_time;
    logic [24:0] dir_time;
    logic fwd;
    logic rev;
    logic stepping;

    // Event slots: 0 secondary first, 1 primary one tick later, 2 mid, 3 end
    localparam int EV_DIR = 0;
    localparam int EV_CNT = 1;
    localparam int EV_MID = 2;
    localparam int EV_END = 3;

    // APB decode, access phase qualified by pready
    assign acc_en = psel & penable & pready;
    assign wr_en = acc_en & pwrite;
    assign mapped = (paddr == `PTG_OFF_STATE) | (paddr == `PTG_OFF_CMD_LO)
        | (paddr == `PTG_OFF_CMD_HI) | (paddr == `PTG_OFF_STATUS)
        | (paddr == `PTG_OFF_MODE) | (paddr == `PTG_OFF_SETUP);

    // State decode; unknown codes behave as reset
    assign is_idle = state_word_reg == `PTG_STATE_IDLE;
    assign is_active = state_word_reg == `PTG_STATE_ACTIVE;
    assign is_reset = ~is_idle & ~is_active;

    // Direction of the command being run
    assign fwd = dir_reg == `PTG_DIR_FWD;
    assign rev = dir_reg == `PTG_DIR_REV;
    assign stepping = fwd | rev;

    // Command pending and step completion
    assign cmd_new = command_word_high_reg[`PTG_CMD_NEW_BIT];
    assign end_last = (eng_reg == ENG_RUN) & hit[EV_END]
        & (count_reg <= 20'h00001);
    assign accept = cmd_new & ~is_reset
        & ((is_idle & (eng_reg == ENG_IDLE)) | end_last);
    assign go_idle = end_last & ~cmd_new;
    assign div_start = (eng_reg == ENG_RUN) & hit[EV_END]
        & (count_reg > 20'h00001)
        & ((acc_reg == `PTG_ACC_ACC) | (acc_reg == `PTG_ACC_DEC));

    // Event time arithmetic for a new step
    assign half_width_shift = width_reg >> 1;
    assign end_event_time = tb_reg + width_reg[24:0];
    assign mid_event_time = end_event_time
        - half_width_shift[24:0];
    assign dir_time = tb_reg + {17'h00000, setup_reg};

    // Rounded width change: (quotient + 1) / 2
    assign delta = 28'((div_quot + 32'h00000001) >> 1);

    // Event match against the time base
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_hit
            assign hit[gi] = tick_reg & pend_reg[gi]
                & (tb_reg == ev_t_reg[gi]);
        end
    endgenerate

    // Width division engine
    ptg_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .start(div_start),
        .numer({2'b00, width_reg, 2'b00}),
        .denom(denom_reg),
        .done(div_done),
        .quot(div_quot)
    );

    // APB handshake and read data, answered one cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (psel & ~penable & ~pwrite) begin
                prdata <= rd_data;
            end
        end
    end

    // Read mux
    always_comb begin
        rd_data = 32'h00000000;
        case (paddr)
            `PTG_OFF_STATE: rd_data = state_word_reg;
            `PTG_OFF_CMD_LO: rd_data = command_word_low_reg;
            `PTG_OFF_CMD_HI: rd_data = command_word_high_reg;
            `PTG_OFF_STATUS: rd_data = {count_reg, 6'h00, eng_reg,
                phase_reg, step_output_secondary, step_output_primary};
            `PTG_OFF_MODE: rd_data = {30'h00000000, mode_reg};
            `PTG_OFF_SETUP: rd_data = {24'h000000, setup_reg};
            default: rd_data = 32'h00000000;
        endcase
    end

    // State word: host writes, engine moves idle and active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_word_reg <= `PTG_STATE_RESET;
        end else if (wr_en & (paddr == `PTG_OFF_STATE)) begin
            state_word_reg <= pwdata;
        end else if (accept) begin
            state_word_reg <= `PTG_STATE_ACTIVE;
        end else if (go_idle) begin
            state_word_reg <= `PTG_STATE_IDLE;
        end
    end

    // Command buffer; a host write wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_word_low_reg <= 32'h00000000;
            command_word_high_reg <= 32'h00000000;
        end else begin
            if (wr_en & (paddr == `PTG_OFF_CMD_LO)) begin
                command_word_low_reg <= pwdata;
            end
            if (wr_en & (paddr == `PTG_OFF_CMD_HI)) begin
                command_word_high_reg <= pwdata;
            end else if (accept) begin
                command_word_high_reg <= 32'h00000000;
            end
        end
    end

    // Mode and direction setup registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= `PTG_MODE_RST;
            setup_reg <= `PTG_SETUP_RST;
        end else begin
            if (wr_en & (paddr == `PTG_OFF_MODE)) begin
                mode_reg <= pwdata[1:0];
            end
            if (wr_en & (paddr == `PTG_OFF_SETUP)) begin
                setup_reg <= pwdata[7:0];
            end
        end
    end

    // Free-running time base, one count per loop period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 8'h00;
            tb_reg <= 25'h0000000;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= 1'b0;
            if (pre_reg == 8'(LOOP_CYC - 1)) begin
                pre_reg <= 8'h00;
                tb_reg <= tb_reg + 25'h0000001;
                tick_reg <= 1'b1;
            end else begin
                pre_reg <= pre_reg + 8'h01;
            end
        end
    end

    // Step sequencer: accept, schedule, run, compute next width
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eng_reg <= ENG_IDLE;
            width_reg <= `PTG_MIN_WIDTH;
            count_reg <= 20'h00000;
            dir_reg <= 4'h0;
            acc_reg <= 2'h0;
            denom_reg <= `PTG_DEN_ACC_SEED;
            phase_reg <= 2'h0;
        end else if (is_reset) begin
            eng_reg <= ENG_IDLE;
            count_reg <= 20'h00000;
        end else if (accept) begin
            width_reg <= command_word_low_reg[`PTG_WID_MSB:0];
            count_reg <= command_word_high_reg[`PTG_CNT_MSB:0];
            dir_reg <= command_word_high_reg[`PTG_DIR_MSB:`PTG_DIR_LSB];
            acc_reg <= command_word_high_reg[`PTG_ACC_MSB:`PTG_ACC_LSB];
            if (command_word_high_reg[`PTG_ACC_MSB:`PTG_ACC_LSB]
                == `PTG_ACC_DEC) begin
                denom_reg <= {10'h000, command_word_high_reg[
                    `PTG_CNT_MSB:0], 2'b00} - `PTG_DEN_DEC_OFS;
            end else begin
                denom_reg <= `PTG_DEN_ACC_SEED;
            end
            eng_reg <= ENG_START;
        end else begin
            case (eng_reg)
                ENG_IDLE: eng_reg <= ENG_IDLE;
                ENG_START: begin
                    if (fwd) begin
                        phase_reg <= phase_reg + 2'h1;
                    end else if (rev) begin
                        phase_reg <= phase_reg - 2'h1;
                    end
                    eng_reg <= ENG_RUN;
                end
                ENG_RUN: begin
                    if (hit[EV_END]) begin
                        count_reg <= count_reg - 20'h00001;
                        if (go_idle) begin
                            eng_reg <= ENG_IDLE;
                        end else if (div_start) begin
                            eng_reg <= ENG_DIV;
                        end else begin
                            eng_reg <= ENG_START;
                        end
                    end
                end
                ENG_DIV: begin
                    if (div_done) begin
                        if (acc_reg == `PTG_ACC_DEC) begin
                            width_reg <= width_reg + delta;
                            denom_reg <= denom_reg - `PTG_DEN_STEP;
                        end else if (width_reg > delta + `PTG_MIN_WIDTH)
                        begin
                            width_reg <= width_reg - delta;
                            denom_reg <= denom_reg + `PTG_DEN_STEP;
                        end else begin
                            width_reg <= `PTG_MIN_WIDTH;
                            denom_reg <= denom_reg + `PTG_DEN_STEP;
                        end
                        eng_reg <= ENG_START;
                    end
                end
                default: eng_reg <= ENG_IDLE;
            endcase
        end
    end

    // Compare slots: cleared while not active, scheduled per step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                ev_t_reg[i] <= 25'h0000000;
            end
            pend_reg <= 4'h0;
        end else if (~is_active) begin
            for (int i = 0; i < 4; i++) begin
                ev_t_reg[i] <= tb_reg + 25'h0000001;
            end
            pend_reg <= 4'h0;
        end else if (eng_reg == ENG_START) begin
            ev_t_reg[EV_DIR] <= dir_time;
            ev_t_reg[EV_CNT] <= dir_time + 25'h0000001;
            ev_t_reg[EV_MID] <= mid_event_time;
            ev_t_reg[EV_END] <= end_event_time;
            pend_reg <= 4'hF;
        end else begin
            pend_reg <= pend_reg & ~hit;
        end
    end

    // Output pins: per-mode actions on the direction, count and mid events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_output_primary <= 1'b0;
            step_output_secondary <= 1'b0;
        end else if (is_reset) begin
            step_output_primary <= 1'b0;
            step_output_secondary <= 1'b0;
        end else if (is_active) begin
            case (ptg_mode_e'(mode_reg))
                PTG_MODE_CWCCW: begin
                    if (hit[EV_CNT]) begin
                        step_output_primary <= fwd;
                        step_output_secondary <= rev;
                    end else if (hit[EV_MID]) begin
                        step_output_primary <= 1'b0;
                        step_output_secondary <= 1'b0;
                    end
                end
                PTG_MODE_QUAD: begin
                    if (hit[EV_CNT] & stepping) begin
                        step_output_primary <= phase_reg[1];
                        step_output_secondary <=
                            phase_reg[1] ^ phase_reg[0];
                    end
                end
                default: begin
                    if (hit[EV_DIR] & stepping) begin
                        step_output_secondary <= fwd;
                    end
                    if (hit[EV_CNT]) begin
                        step_output_primary <= stepping;
                    end else if (hit[EV_MID]) begin
                        step_output_primary <= 1'b0;
                    end
                end
            endcase
        end
        // Idle keeps both pins; the end event never touches a pin
    end

endmodule : ptg_step_generator
`default_nettype wire
